// [hbm_mapper.sv]
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module hbm_mapper
    import hbm_pkg::*;
#(
    parameter int unsigned SLOT_LEN  = SLOT_BITS,
    parameter int unsigned NUM_SLOTS = SLOTS_PER_FRM,
    parameter int unsigned HDR_LEN   = HDR_BITS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // low-priority coded stream
    input  wire logic        low_priority_stream_valid_in,
    input  wire logic        low_priority_stream_bit_in,
    output logic             low_priority_stream_ready_out,
    // high-priority legacy stream
    input  wire logic        high_priority_stream_valid_in,
    input  wire logic [1:0]  high_priority_stream_bits_in,
    output logic             high_priority_stream_ready_out,
    // symbol labels to the constellation stage
    output logic             sym_valid_out,
    output logic      [2:0]  sym_label_out,
    output logic             sym_hdr_first_out,
    input  wire logic        sym_ready_in,
    output logic      [7:0]  deviation_angle_out
);
    import hbm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  rate;
        logic        enable;
        logic [7:0]  angle;
        logic        ack;
        logic [31:0] rdat;
        logic [1:0]  frm_rate;
        logic        in_hdr;
        logic [6:0]  hdr_idx;
        logic [6:0]  bit_idx;
        logic [9:0]  slot;
        logic [15:0] frames;
        logic        out_valid;
        logic [2:0]  out_label;
        logic        out_first;
    } hbm_state_s;

    hbm_state_s st_q;
    hbm_state_s st_d;
    logic       hdr_bit;
    logic       can_load;
    logic       advance;
    logic       wb_req;

    function automatic logic [31:0] rd_mux(input logic [3:0] adr, input hbm_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (adr)
            ADDR_CTRL:   v = {23'h000000, s.enable, 6'h00, s.rate};
            ADDR_ANGLE:  v = {24'h000000, s.angle};
            ADDR_STATUS: v = {15'h0000, s.in_hdr, 6'h00, s.slot};
            ADDR_FRAMES: v = {16'h0000, s.frames};
            default:     v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    hbm_header_gen u_hdr (
        .idx_in  (st_q.hdr_idx),
        .rate_in (st_q.frm_rate),
        .bit_out (hdr_bit)
    );

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // a data label is loaded only with both sources valid; header bits need no lp data
    assign can_load = st_q.enable && (!st_q.out_valid || sym_ready_in);
    assign advance  = can_load && high_priority_stream_valid_in
                      && (st_q.in_hdr || low_priority_stream_valid_in);
    assign high_priority_stream_ready_out = advance;
    assign low_priority_stream_ready_out  = advance && !st_q.in_hdr;
    assign wb_req = wb_cyc_in && wb_stb_in && !st_q.ack;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        st_d.ack = wb_req;
        if (wb_req) begin
            st_d.rdat = wb_we_in ? 32'h0000_0000 : rd_mux(wb_adr_in, st_q);
        end
        if (wb_req && wb_we_in) begin
            if (wb_adr_in == ADDR_CTRL && wb_sel_in[0]) begin
                st_d.rate = wb_dat_in[1:0];
            end
            if (wb_adr_in == ADDR_CTRL && wb_sel_in[1]) begin
                st_d.enable = wb_dat_in[CTRL_EN_BIT];
            end
            if (wb_adr_in == ADDR_ANGLE && wb_sel_in[0]) begin
                st_d.angle = wb_dat_in[7:0];
            end
        end

        if (st_q.out_valid && sym_ready_in) begin
            st_d.out_valid = 1'b0;
        end

        if (advance) begin
            st_d.out_valid = 1'b1;
            // lp bit (header bit while in the header) on top, the two legacy bits below
            st_d.out_label = {st_q.in_hdr ? hdr_bit : low_priority_stream_bit_in,
                              high_priority_stream_bits_in};
            st_d.out_first = st_q.in_hdr && (st_q.hdr_idx == 7'h00);
            if (st_q.in_hdr) begin
                if (st_q.hdr_idx == 7'(HDR_LEN - 1)) begin
                    st_d.in_hdr  = 1'b0;
                    st_d.hdr_idx = 7'h00;
                end else begin
                    st_d.hdr_idx = st_q.hdr_idx + 7'h01;
                end
            end else if (st_q.bit_idx == 7'(SLOT_LEN - 1)) begin
                st_d.bit_idx = 7'h00;
                if (st_q.slot == 10'(NUM_SLOTS - 1)) begin
                    // 720 x 90 = 64 800 bits closes the normal frame
                    st_d.slot     = 10'h000;
                    st_d.in_hdr   = 1'b1;
                    st_d.frm_rate = st_q.rate;
                    st_d.frames   = st_q.frames + 16'h0001;
                end else begin
                    st_d.slot = st_q.slot + 10'h001;
                end
            end else begin
                st_d.bit_idx = st_q.bit_idx + 7'h01;
            end
        end

        // the rate is sampled as the last slot closes and while idle in front of a header, so a frame never
        // mixes rates; a change made mid-frame waits for the next header
        if (st_q.in_hdr && st_q.hdr_idx == 7'h00 && !advance) begin
            st_d.frm_rate = st_d.rate;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_q          <= '0;
            st_q.rate     <= RST_RATE;
            st_q.frm_rate <= RST_RATE;
            st_q.angle    <= RST_ANGLE;
            st_q.in_hdr   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_out          = st_q.ack;
    assign wb_dat_out          = st_q.rdat;
    assign sym_valid_out       = st_q.out_valid;
    assign sym_label_out       = st_q.out_label;
    assign sym_hdr_first_out   = st_q.out_first;
    // the angle only shapes the constellation downstream
    assign deviation_angle_out = st_q.angle;
endmodule

// [hbm_pkg.sv]
package hbm_pkg;
    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam int unsigned SLOT_BITS     = 90;
    localparam int unsigned SLOTS_PER_FRM = 720;
    localparam int unsigned HDR_BITS      = 90;
    localparam int unsigned SYNC_BITS     = 26;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_ANGLE    = 4'h4;
    localparam logic [3:0]  ADDR_STATUS   = 4'h8;
    localparam logic [3:0]  ADDR_FRAMES   = 4'hc;
    localparam int unsigned CTRL_EN_BIT   = 8;
    localparam int unsigned STAT_HDR_BIT  = 16;
    localparam logic [1:0]  RST_RATE      = 2'h0;
    localparam logic [7:0]  RST_ANGLE     = 8'h00;
    // arbitrary value, not tied to any real system
    localparam logic [25:0] SYNC_WORD     = 26'h18d2e37;

    typedef enum logic [1:0] {
        HBM_RATE_1_4,
        HBM_RATE_1_3,
        HBM_RATE_1_2,
        HBM_RATE_3_5
    } hbm_rate_e;
endpackage

`timescale 1ns/10ps
// ----------------------------------------------------------------
// header bit source: sync word, then the rate code repeated
// ----------------------------------------------------------------
module hbm_header_gen
    import hbm_pkg::*;
(
    input  wire logic [6:0] idx_in,
    input  wire logic [1:0] rate_in,
    output logic            bit_out
);
    always_comb begin
        // repetition makes the rate field robust at low signal to noise
        if (idx_in < 7'(SYNC_BITS)) begin
            bit_out = SYNC_WORD[5'(SYNC_BITS - 1) - idx_in[4:0]];
        end else begin
            bit_out = idx_in[0] ? rate_in[0] : rate_in[1];
        end
    end
endmodule

// [hbm_mapper_properties.sv]
`timescale 1ns/10ps
module hbm_mapper_properties #(
    parameter int unsigned SLOT_LEN  = 90,
    parameter int unsigned NUM_SLOTS = 720,
    parameter int unsigned HDR_LEN   = 90
) (
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic       wb_cyc_in,
    input wire logic       wb_stb_in,
    input wire logic       wb_ack_out,
    input wire logic       low_priority_stream_valid_in,
    input wire logic       low_priority_stream_bit_in,
    input wire logic       low_priority_stream_ready_out,
    input wire logic       high_priority_stream_valid_in,
    input wire logic [1:0] high_priority_stream_bits_in,
    input wire logic       high_priority_stream_ready_out,
    input wire logic       sym_valid_out,
    input wire logic [2:0] sym_label_out,
    input wire logic       sym_hdr_first_out,
    input wire logic       sym_ready_in
);
    localparam int unsigned FRM = HDR_LEN + SLOT_LEN * NUM_SLOTS;
    logic        lo_take;
    logic        hi_take;
    logic [15:0] pos_q;
    assign lo_take = low_priority_stream_valid_in && low_priority_stream_ready_out;
    assign hi_take = high_priority_stream_valid_in && high_priority_stream_ready_out;
    // label position in the frame; every label takes exactly one high pair
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) pos_q <= 16'h0;
        else if (hi_take) pos_q <= (pos_q == 16'(FRM - 1)) ? 16'h0 : pos_q + 16'h1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_emit;
        hi_take ##1 sym_valid_out;
    endsequence
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
    a_label_hold: assert property (sym_valid_out && !sym_ready_in |=> sym_valid_out && $stable(sym_label_out))
        else $error("label lost");
    a_hi_bits: assert property (hi_take |=> sym_valid_out && sym_label_out[1:0] == $past(high_priority_stream_bits_in))
        else $error("high bits");
    a_lo_bit: assert property (lo_take |=> sym_label_out[2] == $past(low_priority_stream_bit_in))
        else $error("low bit");
    a_lo_paired: assert property (lo_take |-> hi_take) else $error("low bit alone");
    a_hdr_no_lo: assert property (hi_take && pos_q < HDR_LEN |-> !low_priority_stream_ready_out)
        else $error("low taken in header");
    a_data_lo: assert property (hi_take && pos_q >= HDR_LEN |-> lo_take) else $error("data without low bit");
    a_first_mark: assert property (s_emit |-> sym_hdr_first_out == ($past(pos_q) == 16'h0))
        else $error("marker misplaced");
endmodule
bind hbm_mapper hbm_mapper_properties #(.SLOT_LEN(SLOT_LEN), .NUM_SLOTS(NUM_SLOTS), .HDR_LEN(HDR_LEN)) u_props (.*);

// [hbm_src_model.sv]
`timescale 1ns/10ps
module hbm_src_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       lo_ready_in,
    input  wire logic       hi_ready_in,
    output logic            lo_valid_out,
    output logic            lo_bit_out,
    output logic            hi_valid_out,
    output logic      [1:0] hi_bits_out
);
    int seed = 82;
    // beats held until taken; idle data keeps changing so stale bits match only by chance
    always @(posedge clk_in) begin
        if (rst_in) begin
            lo_valid_out <= 1'b0;
            lo_bit_out   <= 1'b0;
            hi_valid_out <= 1'b0;
            hi_bits_out  <= 2'h0;
        end else begin
            if (!lo_valid_out || lo_ready_in) begin
                lo_valid_out <= ($random(seed) % 4) != 0; // random bits, with random gaps in valid
                lo_bit_out   <= $random(seed);
            end
            if (!hi_valid_out || hi_ready_in) begin
                hi_valid_out <= ($random(seed) % 4) != 0; // random pairs, with random gaps in valid
                hi_bits_out  <= $random(seed);
            end
        end
    end
endmodule

// [hbm_mapper_tb.sv]
`timescale 1ns/10ps
module hbm_mapper_tb;
    import hbm_pkg::*;
    localparam int unsigned FRM = HDR_BITS + SLOT_BITS * 2;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cyc = 1'b0, we = 1'b0, rdy = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, dout, rd;
    logic        ack, lo_v, lo_b, lo_r, hi_v, hi_r, s_v, s_f;
    logic [1:0]  hi_b;
    logic [2:0]  s_l;
    logic [7:0]  ang;
    logic [89:0] hdr;
    int          errors = 0, checked = 0, seed = 82, n = 0, mk = 0;
    hbm_mapper #(.NUM_SLOTS(2)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack),
        .low_priority_stream_valid_in(lo_v), .low_priority_stream_bit_in(lo_b), .low_priority_stream_ready_out(lo_r),
        .high_priority_stream_valid_in(hi_v), .high_priority_stream_bits_in(hi_b),
        .high_priority_stream_ready_out(hi_r), .sym_valid_out(s_v), .sym_label_out(s_l), .sym_hdr_first_out(s_f),
        .sym_ready_in(rdy), .deviation_angle_out(ang));
    hbm_src_model src (.clk_in(ref_clk_in), .rst_in(rst_in), .lo_ready_in(lo_r), .hi_ready_in(hi_r),
        .lo_valid_out(lo_v), .lo_bit_out(lo_b), .hi_valid_out(hi_v), .hi_bits_out(hi_b));
    initial forever #20 ref_clk_in = ~ref_clk_in;
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        int k;
        @(posedge ref_clk_in);
        {cyc, we, adr, sel, wdat} <= {1'b1, w, a, s, d};
        k = 0;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dout;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask
    function automatic logic exp_hdr(input logic [1:0] r, input int i);
        if (i < SYNC_BITS) return SYNC_WORD[SYNC_BITS - 1 - i];
        return (i % 2 == 0) ? r[1] : r[0];
    endfunction
    // label monitor; the downstream stage stalls at random
    always @(posedge ref_clk_in) begin
        rdy <= ($random(seed) % 4) != 0;
        if (s_v === 1'b1 && rdy) begin
            if (s_f) begin
                if (mk != 0) check("frame length", 32'(n), 32'(FRM));
                n = 0;
                mk++;
            end
            if (n < HDR_BITS) hdr[89 - n] = s_l[2];
            n++;
        end
    end
    initial begin
        int k, m;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        wb(1'b1, 4'h2, 4'hf, 32'h1ff);
        wb(1'b0, ADDR_CTRL, 4'hf, 32'h0);
        check("ctrl", rd, {22'h0, 1'b0, 7'h0, RST_RATE});
        wb(1'b1, ADDR_ANGLE, 4'h1, 32'ha5);
        wb(1'b1, ADDR_ANGLE, 4'h0, 32'hff);
        wb(1'b0, ADDR_ANGLE, 4'hf, 32'h0);
        check("angle", rd, 32'ha5);
        check("angle out", {24'h0, ang}, 32'ha5);
        $display("registers done");
        for (int r = 0; r < 4; r++) begin
            wb(1'b1, ADDR_CTRL, 4'h3, 32'h100 | r);
            m = mk;
            for (k = 0; k < 4000 && !(mk != m && n >= HDR_BITS); k++) @(posedge ref_clk_in);
            if (k >= 4000) begin
                errors++;
                give_verdict();
            end
            for (int i = 0; i < HDR_BITS; i++) check("header bit", 32'(hdr[89 - i]), 32'(exp_hdr(r[1:0], i)));
            $display("rate %0d done", r);
        end
        wb(1'b1, ADDR_CTRL, 4'h2, 32'h0);
        repeat (3) @(posedge ref_clk_in);
        check("readies off", {30'h0, lo_r, hi_r}, 32'h0);
        $display("stall done");
        give_verdict();
    end
endmodule
